// file: core/ccp_pkg.sv
// Package of constants and types for the capture, compare and PWM unit
package ccp_pkg;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_VAL_LO  = 8'h04;
  localparam logic [7:0] ADDR_VAL_HI  = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG  = 8'h10;

  localparam int         FLAG_BIT     = 0;

  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_FALL    = 4'h4;
  localparam logic [3:0] MODE_RISE    = 4'h5;
  localparam logic [3:0] MODE_RISE4   = 4'h6;
  localparam logic [3:0] MODE_RISE16  = 4'h7;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLEAR   = 4'h9;
  localparam logic [3:0] MODE_SOFT    = 4'ha;
  localparam logic [3:0] MODE_TRIG    = 4'hb;

  localparam logic [1:0] GROUP_CAP    = 2'h1;
  localparam logic [1:0] GROUP_PWM    = 2'h3;

  localparam logic [3:0] PRESC_LAST4  = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;

  localparam logic [1:0] CFG_SINGLE   = 2'h0;
  localparam logic [1:0] CFG_FWD      = 2'h1;
  localparam logic [1:0] CFG_HALF     = 2'h2;
  localparam logic [1:0] CFG_REV      = 2'h3;

  localparam logic [3:0] USE_NONE     = 4'h0;
  localparam logic [3:0] USE_HALF     = 4'h3;
  localparam logic [3:0] USE_FULL     = 4'hf;

  typedef struct packed {
    logic [1:0] output_config_field;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_field;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] steering;
    logic [2:0] spare;
    logic       timer_select;
  } config_t;

  typedef struct packed {
    logic pwm_out_d;
    logic pwm_out_c;
    logic pwm_out_b;
    logic pwm_out_a;
  } pwm_pins_t;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

endpackage : ccp_pkg

// file: core/capture_compare_pwm_unit.sv
// Capture, compare and enhanced PWM unit with a Wishbone register slave
// Operation
// - Capture copies selected 16-bit timer count
// - Capture event falling, rising, 4th, 16th rise
// - Capture sets flag; software clears it
// - New capture overwrites held value silently
// - Port latch edge counts when pin outputs
// - Prescaler cleared when off, leaving capture, reset
// - Prescaler kept across prescaler setting changes
// - Compare register continuously matched against timer
// - Match drives high, low, toggles or follows latch
// - Match sets flag with pin action
// - Zero control write forces compare latch low
// - Mode 1010 only sets flag on match
// - Mode 1011 trigger resets time base timer
// - Trigger starts conversion if converter enabled
// - Ten-bit PWM on up to four outputs
// - Config 00 single, 10 half, 01/11 full
// - Half uses two outputs, full four, single steered
// - PWM polarity set by mode field
// - PWM waits for new period before output
// - Unused outputs freed for alternate functions
// - Capture encodings 0100 to 0111
// - Modes 1000, 1001 initialize pin; 0010 toggles
// - Modes 1100-1111 pick pair polarities
// - Duty is duty register over two low bits
`timescale 1ns/1ns

module capture_compare_pwm_unit (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [15:0]         first_timer_count,
  input  wire logic [15:0]         second_timer_count,
  input  wire logic                unit_pin_in,
  output logic                     unit_pin_out,
  output logic                     unit_pin_oe_n,
  input  wire logic                pin_is_output,
  input  wire logic                port_latch,
  input  wire logic                adc_enabled,
  input  wire logic [9:0]          pwm_base,
  input  wire logic                pwm_period_start,
  output ccp_pkg::pwm_pins_t       pwm_pins,
  output logic      [3:0]          pwm_use,
  output logic                     unit_irq_flag,
  output logic                     special_event,
  output logic                     reset_first_timer,
  output logic                     reset_second_timer,
  output logic                     adc_start
);

  typedef struct packed {
    ccp_pkg::ctrl_t     ctrl;
    ccp_pkg::config_t   cfg;
    logic [15:0]        value;
    logic               flag;
    logic               pin_meta;
    logic               pin_sync;
    logic               src_prev;
    logic [3:0]         presc;
    logic               cmp_latch;
    logic               match_prev;
    logic               pin_out;
    logic               pwm_run;
    logic [9:0]         duty;
    ccp_pkg::pwm_pins_t pins;
    logic               trig;
    logic               trig_first;
    logic               trig_second;
    logic               adc;
    logic               ack;
    logic [7:0]         rdata;
  } state_t;

  state_t      s;
  state_t      next_s;

  logic        bus_hit;
  logic        wr;
  logic [3:0]  mode;
  logic [1:0]  group;
  logic [15:0] sel_timer;
  logic        src;
  logic        rise;
  logic        fall;
  logic        cap;
  logic        cmp_mode;
  logic        drive;
  logic        match;
  logic        hit;
  logic        raw;
  logic [3:0]  act;
  logic [3:0]  pol;

  always_comb begin
    next_s    = s;
    bus_hit   = wb_cyc_i & wb_stb_i & ~s.ack;
    wr        = bus_hit & wb_we_i & wb_sel_i[0];
    mode      = s.ctrl.unit_mode_field;
    group     = mode[3:2];
    sel_timer = s.cfg.timer_select ? second_timer_count : first_timer_count;
    cap       = 1'b0;
    hit       = 1'b0;
    act       = 4'h0;

    // Two-stage pin synchroniser
    next_s.pin_meta = unit_pin_in;
    next_s.pin_sync = s.pin_meta;

    // Edge source follows the port latch when the pin is an output
    src  = pin_is_output ? port_latch : s.pin_sync;
    rise = src & ~s.src_prev;
    fall = ~src & s.src_prev;
    next_s.src_prev = src;

    // Bus answer
    next_s.ack = bus_hit;
    if (bus_hit && !wb_we_i) begin
      case (wb_adr_i)
        ccp_pkg::ADDR_CTRL:   next_s.rdata = s.ctrl;
        ccp_pkg::ADDR_VAL_LO: next_s.rdata = s.value[7:0];
        ccp_pkg::ADDR_VAL_HI: next_s.rdata = s.value[15:8];
        ccp_pkg::ADDR_STATUS: next_s.rdata = {7'h00, s.flag};
        ccp_pkg::ADDR_CONFIG: next_s.rdata = s.cfg;
        default:              next_s.rdata = 8'h00;
      endcase
    end

    // Register writes
    if (wr) begin
      case (wb_adr_i)
        ccp_pkg::ADDR_CTRL: begin
          next_s.ctrl = wb_dat_i[7:0];
          if (wb_dat_i[7:0] == ccp_pkg::CTRL_RESET) begin
            next_s.cmp_latch = 1'b0;
          end else if (wb_dat_i[3:0] == ccp_pkg::MODE_SET) begin
            next_s.cmp_latch = 1'b0;
          end else if (wb_dat_i[3:0] == ccp_pkg::MODE_CLEAR) begin
            next_s.cmp_latch = 1'b1;
          end
        end
        ccp_pkg::ADDR_VAL_LO: next_s.value[7:0] = wb_dat_i[7:0];
        ccp_pkg::ADDR_VAL_HI: next_s.value[15:8] = wb_dat_i[7:0];
        ccp_pkg::ADDR_CONFIG: next_s.cfg = wb_dat_i[7:0];
        default: begin
        end
      endcase
    end

    // Capture event selection and prescaler
    if (group != ccp_pkg::GROUP_CAP) begin
      next_s.presc = 4'h0;
    end else begin
      case (mode)
        ccp_pkg::MODE_FALL: cap = fall;
        ccp_pkg::MODE_RISE: cap = rise;
        ccp_pkg::MODE_RISE4: begin
          if (rise) begin
            if (s.presc >= ccp_pkg::PRESC_LAST4) begin
              cap          = 1'b1;
              next_s.presc = 4'h0;
            end else begin
              next_s.presc = s.presc + 4'h1;
            end
          end
        end
        ccp_pkg::MODE_RISE16: begin
          if (rise) begin
            if (s.presc == ccp_pkg::PRESC_LAST16) begin
              cap          = 1'b1;
              next_s.presc = 4'h0;
            end else begin
              next_s.presc = s.presc + 4'h1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Captured count overwrites the held value
    if (cap) begin
      next_s.value = sel_timer;
    end

    // Compare modes
    case (mode)
      ccp_pkg::MODE_TOGGLE,
      ccp_pkg::MODE_SET,
      ccp_pkg::MODE_CLEAR,
      ccp_pkg::MODE_SOFT,
      ccp_pkg::MODE_TRIG: cmp_mode = 1'b1;
      default:            cmp_mode = 1'b0;
    endcase

    case (mode)
      ccp_pkg::MODE_TOGGLE,
      ccp_pkg::MODE_SET,
      ccp_pkg::MODE_CLEAR: drive = 1'b1;
      default:             drive = 1'b0;
    endcase

    match = cmp_mode & (s.value == sel_timer);
    next_s.match_prev = match;
    if (match && !s.match_prev) begin
      hit = 1'b1;
      case (mode)
        ccp_pkg::MODE_TOGGLE: next_s.cmp_latch = ~s.cmp_latch;
        ccp_pkg::MODE_SET:    next_s.cmp_latch = 1'b1;
        ccp_pkg::MODE_CLEAR:  next_s.cmp_latch = 1'b0;
        default: begin
        end
      endcase
    end

    // Pin follows the compare latch or the port latch
    next_s.pin_out = drive ? next_s.cmp_latch : port_latch;

    // Special event trigger
    next_s.trig        = hit & (mode == ccp_pkg::MODE_TRIG);
    next_s.trig_first  = next_s.trig & ~s.cfg.timer_select;
    next_s.trig_second = next_s.trig & s.cfg.timer_select;
    next_s.adc         = next_s.trig & adc_enabled;

    // Interrupt flag, a new event wins over a software clear
    if (wr && wb_adr_i == ccp_pkg::ADDR_STATUS && wb_dat_i[ccp_pkg::FLAG_BIT]) begin
      next_s.flag = 1'b0;
    end
    if (cap || hit) begin
      next_s.flag = 1'b1;
    end

    // PWM start and duty latch at period boundary
    if (group != ccp_pkg::GROUP_PWM) begin
      next_s.pwm_run = 1'b0;
    end else if (pwm_period_start) begin
      next_s.pwm_run = 1'b1;
      next_s.duty    = {s.value[7:0], s.ctrl.duty_low_bits};
    end

    raw = s.pwm_run & (pwm_base < s.duty);

    // Active-high pattern per configuration, bits d c b a
    case (s.ctrl.output_config_field)
      ccp_pkg::CFG_SINGLE: act = {4{raw}} & s.cfg.steering;
      ccp_pkg::CFG_HALF:   act = {2'b00, ~raw & s.pwm_run, raw};
      ccp_pkg::CFG_FWD:    act = {raw, 1'b0, 1'b0, s.pwm_run};
      ccp_pkg::CFG_REV:    act = {1'b0, s.pwm_run, raw, 1'b0};
      default:             act = 4'h0;
    endcase

    // Pair polarity, bit 1 for a and c, bit 0 for b and d
    pol = {mode[0], mode[1], mode[0], mode[1]};

    if (group == ccp_pkg::GROUP_PWM) begin
      next_s.pins = act ^ pol;
    end else begin
      next_s.pins = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs in use by the PWM; the rest stay free for other functions
  always_comb begin
    if (group != ccp_pkg::GROUP_PWM) begin
      pwm_use = ccp_pkg::USE_NONE;
    end else begin
      case (s.ctrl.output_config_field)
        ccp_pkg::CFG_SINGLE: pwm_use = s.cfg.steering;
        ccp_pkg::CFG_HALF:   pwm_use = ccp_pkg::USE_HALF;
        default:             pwm_use = ccp_pkg::USE_FULL;
      endcase
    end
  end

  assign wb_dat_o           = {24'h000000, s.rdata};
  assign wb_ack_o           = s.ack;
  assign unit_pin_out       = s.pin_out;
  assign unit_pin_oe_n      = ~pin_is_output;
  assign pwm_pins           = s.pins;
  assign unit_irq_flag      = s.flag;
  assign special_event      = s.trig;
  assign reset_first_timer  = s.trig_first;
  assign reset_second_timer = s.trig_second;
  assign adc_start          = s.adc;

endmodule : capture_compare_pwm_unit

// file: testbench/ccp_props.sv
// Port checks for the capture, compare and PWM unit
`timescale 1ns/1ns
module ccp_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic       wb_ack_o,
  input wire logic       unit_irq_flag,
  input wire logic       special_event,
  input wire logic       reset_first_timer,
  input wire logic       reset_second_timer,
  input wire logic       adc_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ack_take:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_flag_sticky:
    assert property (unit_irq_flag && !(wb_we_i && wb_adr_i == ccp_pkg::ADDR_STATUS)
      |=> unit_irq_flag) else $error("flag dropped");
  a_trig_timer:
    assert property (special_event |-> reset_first_timer ^ reset_second_timer)
      else $error("trigger without one timer reset");
  a_reset_cause:
    assert property (reset_first_timer || reset_second_timer |-> special_event)
      else $error("timer reset without trigger");
  a_adc_cause:
    assert property (adc_start |-> special_event) else $error("conversion without trigger");
  a_trig_flag:
    assert property (special_event |-> unit_irq_flag) else $error("trigger without flag");
  a_trig_once:
    assert property (special_event |=> !special_event) else $error("trigger repeated");
endmodule : ccp_props

bind capture_compare_pwm_unit ccp_props u_props (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .unit_irq_flag,
  .special_event, .reset_first_timer, .reset_second_timer, .adc_start
);

// file: testbench/time_base_model.sv
// Timer pair and PWM time base on the far side of the unit
`timescale 1ns/1ns
module time_base_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        reset_first_timer,
  input  wire logic        reset_second_timer,
  output logic      [15:0] first_timer_count,
  output logic      [15:0] second_timer_count,
  output logic      [9:0]  pwm_base,
  output logic             pwm_period_start
);
  assign pwm_period_start = pwm_base == 10'h000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_timer_count <= 16'h0000;
      second_timer_count <= 16'h8000;
      pwm_base <= 10'h000;
    end else begin
      pwm_base <= {4'h0, pwm_base[5:0] + 6'h01};
      if (reset_first_timer) first_timer_count <= 16'h0000;
      else if (run) first_timer_count <= first_timer_count + 16'h0001;
      if (reset_second_timer) second_timer_count <= 16'h0000;
      else if (run) second_timer_count <= second_timer_count + 16'h0001;
    end
  end
endmodule : time_base_model

// file: testbench/test_capture_compare_pwm_unit.sv
// Self-checking bench for the capture, compare and PWM unit
`timescale 1ns/1ns
module test_capture_compare_pwm_unit;
  logic        clk = '0, rst_n = '0, wb_cyc_i = '0, wb_we_i = '0, unit_pin_in = '0;
  logic        pin_is_output = '0, port_latch = '0, adc_enabled = '0, run = '0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic [15:0] first_timer_count, second_timer_count, v;
  logic [9:0]  pwm_base;
  logic [3:0]  pwm_use;
  logic        wb_ack_o, unit_pin_out, unit_pin_oe_n, unit_irq_flag, pwm_period_start;
  logic        special_event, reset_first_timer, reset_second_timer, adc_start;
  ccp_pkg::pwm_pins_t pwm_pins;
  int          errors = 0, total_checks = 0, cycles = 0, n_sev = 0, n_adc = 0, i, k, hi[4];
  int          n_rs2 = 0;
  int          cn[4] = '{1, 1, 4, 16};
  int          ph[16] = '{36, 36, 36, 36, 36, 36, -1, -1, 0, 0, 128, 36, 128, 92, 0, 128};
  logic [3:0]  cm[4] = '{4'h5, 4'h4, 4'h6, 4'h7};
  logic [3:0]  om[6] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'hb, 4'hb};
  logic [5:0]  ox = 6'h05;
  logic [1:0]  pc[4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  logic [3:0]  pu[4] = '{4'hf, 4'h3, 4'hf, 4'hf};
  capture_compare_pwm_unit dut (
    .clk, .rst_n, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .first_timer_count, .second_timer_count, .unit_pin_in,
    .unit_pin_out, .unit_pin_oe_n, .pin_is_output, .port_latch, .adc_enabled, .pwm_base,
    .pwm_period_start, .pwm_pins, .pwm_use, .unit_irq_flag, .special_event,
    .reset_first_timer, .reset_second_timer, .adc_start
  );
  time_base_model partner (
    .clk, .rst_n, .run, .reset_first_timer, .reset_second_timer, .first_timer_count,
    .second_timer_count, .pwm_base, .pwm_period_start
  );
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    n_sev <= n_sev + int'(special_event);
    n_adc <= n_adc + int'(adc_start);
    n_rs2 <= n_rs2 + int'(reset_second_timer);
    if (cycles == 30000) begin
      errors++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rdat);
  endtask : rd
  task automatic pulse;
    unit_pin_in <= 1'b1;
    tick(6);
    unit_pin_in <= 1'b0;
    tick(6);
  endtask : pulse
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    tick(10);
    rst_n <= 1'b1;
    run <= 1'b1;
    tick(37);
    run <= 1'b0;
    rd(8'h00, 32'h0, "control reset");
    wr(8'h14, 8'hff);
    rd(8'h14, 32'h0, "unmapped");
    for (i = 0; i < 4; i++) begin
      wr(8'h10, 8'(i % 2));
      wr(8'h00, 8'h00);
      wr(8'h00, {4'h0, cm[i]});
      wr(8'h0c, 8'h01);
      repeat (cn[i] - 1) pulse();
      rd(8'h0c, 32'h0, "flag early");
      pulse();
      rd(8'h0c, 32'h1, "capture flag");
      v = i % 2 ? second_timer_count : first_timer_count;
      rd(8'h04, 32'(v[7:0]), "value low");
      rd(8'h08, 32'(v[15:8]), "value high");
    end
    wr(8'h00, {4'h0, 4'h6});
    repeat (2) pulse();
    wr(8'h00, 8'h00);
    wr(8'h00, {4'h0, 4'h6});
    wr(8'h0c, 8'h01);
    repeat (3) pulse();
    rd(8'h0c, 32'h0, "prescaler cleared");
    wr(8'h00, {4'h0, 4'h7});
    wr(8'h0c, 8'h01);
    repeat (12) pulse();
    rd(8'h0c, 32'h0, "prescaler kept early");
    pulse();
    rd(8'h0c, 32'h1, "prescaler kept capture");
    wr(8'h00, {4'h0, 4'h5});
    wr(8'h0c, 8'h01);
    pin_is_output <= 1'b1;
    port_latch <= 1'b1;
    tick(8);
    chk("pin direction", 32'h0, 32'(unit_pin_oe_n));
    rd(8'h0c, 32'h1, "latch capture");
    pin_is_output <= 1'b0;
    port_latch <= 1'b0;
    run <= 1'b1;
    wr(8'h10, 8'h00);
    for (i = 0; i < 6; i++) begin
      v = first_timer_count + 16'h0050;
      adc_enabled <= i == 4;
      wr(8'h04, v[7:0]);
      wr(8'h08, v[15:8]);
      wr(8'h00, {4'h0, om[i]});
      wr(8'h0c, 8'h01);
      tick(90);
      chk("compare pin", 32'(ox[i]), 32'(unit_pin_out));
      rd(8'h0c, 32'h1, "match flag");
    end
    chk("trigger count", 32'h2, 32'(n_sev));
    chk("conversions", 32'h1, 32'(n_adc));
    chk("second timer resets", 32'h0, 32'(n_rs2));
    chk("timer restarted", 32'h1, 32'(first_timer_count < 16'h003c));
    wr(8'h00, 8'h00);
    port_latch <= 1'b1;
    wr(8'h00, {4'h0, 4'h2});
    tick(2);
    chk("latch forced low", 32'h0, 32'(unit_pin_out));
    port_latch <= 1'b0;
    run <= 1'b0;
    wr(8'h10, 8'hf0);
    for (i = 0; i < 4; i++) begin
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h04);
      wr(8'h00, {pc[i], 2'h2, 4'hc + 4'(i)});
      tick(140);
      hi = '{0, 0, 0, 0};
      repeat (128) begin
        @(posedge clk);
        for (k = 0; k < 4; k++) hi[k] += int'(pwm_pins[k]);
      end
      chk("pins in use", 32'(pu[i]), 32'(pwm_use));
      for (k = 0; k < 4; k++) begin
        if (ph[4 * i + k] >= 0) chk("pwm count", ph[4 * i + k], hi[k]);
      end
    end
    final_report();
  end
endmodule : test_capture_compare_pwm_unit
